// file: logic/csw_map.vh
/*
 Chip-select and wait-state unit constants: register indices, field positions,
 reset values and decode widths. Assumes a 20-bit memory address, a 20-bit
 I/O address and 16-bit register data.
*/
`ifndef CSW_MAP_VH
`define CSW_MAP_VH

// ----------------------------------------------------------------------
// Register indices on the register port
// ----------------------------------------------------------------------
`define CSW_IDX_UPPER      3'h0
`define CSW_IDX_LOWER      3'h1
`define CSW_IDX_PBASE      3'h2
`define CSW_IDX_MID        3'h3
`define CSW_IDX_AUX        3'h4
`define CSW_IDX_RSTCFG     3'h5
`define CSW_IDX_STATUS     3'h6

// ----------------------------------------------------------------------
// Common control fields
// ----------------------------------------------------------------------
`define CSW_WAIT_LO        0
`define CSW_WAIT_HI        1
`define CSW_RDY_BIT        2
`define CSW_EXT_BIT        3
`define CSW_DA_BIT         7
// Base sits in bits 15-6, as address bits 19-10
`define CSW_BASE_LO        6
`define CSW_BASE_HI        15
// Upper and lower boundaries use bits 15-8 (address bits 19-12), clear of DA
`define CSW_BOUND_LO       8

// Aux register: block size index, peripheral space, pin mode
`define CSW_AUX_SIZE_LO    8
`define CSW_AUX_SIZE_HI    10
`define CSW_AUX_MEM_BIT    6
`define CSW_AUX_ADDR_BIT   7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSW_UPPER_RST      16'hf03f
`define CSW_ZERO16         16'h0000
`define CSW_PBLOCK_SHIFT   8
`define CSW_PCB_BASE       10'h3ff
`define CSW_PCB_SPAN_SHIFT 8
`endif

// file: logic/csw_unit.v
/*
 Chip-select decoder with wait-state and ready sequencing, plus the latch
 that samples the address/data bus during reset.
 Assumes: a bus unit issues one-cycle cycle_start with address and type,
 then holds the cycle until cycle_done; ready inputs come from pins.
*/
// Operation
// [RULE1] Capture bus value while reset low, keep
// [RULE2] Board drives configuration pattern during reset
// [RULE3] Selects follow CPU and DMA cycles alike
// [RULE4] Six memory, six peripheral 256-byte selects; code has seven peripheral
// [RULE5] Control write enables decode despite pin use
// [RULE6] Bit2 ready enable, bits1-0 wait count
// [RULE7] Bit3 extends low peripheral waits 5-15
// [RULE8] Programmed waits finish before ready counts; code samples ready while waits remain
// [RULE9] Late ready adds two waits after ready
// [RULE10] Control block select: zero waits, no ready
// [RULE11] Address-disable suppresses address phase drive
// [RULE12] Overlapping selects must share ready settings
// [RULE13] Mid/peripheral timing applies under pin reuse
// [RULE14] Fifth select timed; upper two off as address
// [RULE15] Upper select on at reset, 3 waits
// [RULE16] Upper boundary programmable 64K to 512K
// [RULE17] Low select enabled by register access
// [RULE18] Mid block anywhere outside other regions
// [RULE19] Mid enabled after both registers accessed
// [RULE20] Mid selects assert half clock later
// [RULE21] Peripheral base memory or I/O space
// [RULE22] Aux picks select or address pin mode
// [RULE23] Peripheral selects off until both accessed
// [RULE24] Selects active low, idle high otherwise; pcb_select is active high
`timescale 1ns/10ps
`include "csw_map.vh"

module csw_unit #(
   parameter AW = 20,                      // Memory address width
   parameter DW = 16                       // Register width
)(
   input  wire          core_clk,
   input  wire          reset_n,
   input  wire [15:0]   muxed_addr_data_bus,
   input  wire          cycle_start,
   input  wire [AW-1:0] cycle_addr,
   input  wire          cycle_io,
   input  wire          cycle_done,
   input  wire          ext_ready,
   input  wire [2:0]    reg_addr,
   input  wire [DW-1:0] reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [DW-1:0] reg_rdata,
   output reg           upper_mem_select_n,
   output reg           lower_mem_select_n,
   output reg  [3:0]    mid_mem_selects_n,
   output reg  [3:0]    periph_selects_low_n,
   output reg           periph_select_four_n,
   output reg           periph_select_five_n,
   output reg           periph_select_six_n,
   output reg           pcb_select,
   output reg           address_disable,
   output wire          cycle_ready,
   output reg           addr_pins_mode
);

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
// Wait count from control field and extension bit
function [3:0] wait_of;
   input [15:0] c;
   input        ext_ok;
   begin
      case ({ext_ok & c[`CSW_EXT_BIT], c[`CSW_WAIT_HI:`CSW_WAIT_LO]}) // [RULE7]
         3'h4:    wait_of = 4'h5;
         3'h5:    wait_of = 4'h7;
         3'h6:    wait_of = 4'h9;
         3'h7:    wait_of = 4'hf;
         default: wait_of = {2'h0, c[`CSW_WAIT_HI:`CSW_WAIT_LO]}; // [RULE6]
      endcase
   end
endfunction

// ----------------------------------------------------------------------
// Synchronisers and registers
// ----------------------------------------------------------------------
reg  [15:0] bus_s1_reg;                    // First stage, read by second only
reg  [15:0] bus_s2_reg;                    // Second stage
reg         rdy_s1_reg;                    // Ready first stage
reg         rdy_s2_reg;                    // Ready second stage
reg  [15:0] rstcfg_reg;                    // Reset configuration latch
reg  [15:0] upper_reg;                     // Upper region control
reg  [15:0] lower_reg;                     // Lower region control
reg  [15:0] pbase_reg;                     // Peripheral base control
reg  [15:0] mid_reg;                       // Midrange control
reg  [15:0] aux_reg;                       // Auxiliary control
reg         lower_en_reg;                  // Lower decode enabled
reg         mid_seen_reg;                  // Midrange register accessed
reg         aux_seen_reg;                  // Aux register accessed
reg         pbase_seen_reg;                // Peripheral base accessed
reg         in_reset_reg;                  // Previous reset level

wire        acc_hit = reg_wr | reg_rd;

always @(posedge core_clk) begin
   bus_s1_reg <= muxed_addr_data_bus;
   bus_s2_reg <= bus_s1_reg;
   rdy_s1_reg <= ext_ready;
   rdy_s2_reg <= rdy_s1_reg;
end

// Config latch: tracks the bus during reset, frozen afterwards.
// The bus is undriven by us in reset, so the board pattern lands here.
always @(posedge core_clk) begin
   in_reset_reg <= ~reset_n;
   if (!reset_n || in_reset_reg)
      rstcfg_reg <= bus_s2_reg; // [RULE1] [RULE2]
end

// Register writes and access tracking
always @(posedge core_clk) begin
   if (!reset_n) begin
      upper_reg      <= `CSW_UPPER_RST; // [RULE15]
      lower_reg      <= `CSW_ZERO16;
      pbase_reg      <= `CSW_ZERO16;
      mid_reg        <= `CSW_ZERO16;
      aux_reg        <= `CSW_ZERO16;
      lower_en_reg   <= 1'b0;
      mid_seen_reg   <= 1'b0;
      aux_seen_reg   <= 1'b0;
      pbase_seen_reg <= 1'b0;
   end else begin
      // Any access, read or write, counts toward enabling
      if (acc_hit && reg_addr == `CSW_IDX_LOWER)
         lower_en_reg <= 1'b1; // [RULE17]
      if (acc_hit && reg_addr == `CSW_IDX_MID)
         mid_seen_reg <= 1'b1; // [RULE19]
      if (acc_hit && reg_addr == `CSW_IDX_AUX)
         aux_seen_reg <= 1'b1; // [RULE19] [RULE23]
      if (acc_hit && reg_addr == `CSW_IDX_PBASE)
         pbase_seen_reg <= 1'b1; // [RULE23]
      if (reg_wr) begin
         case (reg_addr)
            `CSW_IDX_UPPER: upper_reg <= reg_wdata; // [RULE16]
            `CSW_IDX_LOWER: lower_reg <= reg_wdata;
            `CSW_IDX_PBASE: pbase_reg <= reg_wdata;
            `CSW_IDX_MID:   mid_reg   <= reg_wdata;
            `CSW_IDX_AUX:   aux_reg   <= reg_wdata;
            default: ;
         endcase
      end
   end
end

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------
wire [9:0] a_hi     = cycle_addr[AW-1:AW-10];  // 1 Kbyte granules
wire [7:0] up_bound = upper_reg[`CSW_BASE_HI:`CSW_BOUND_LO];  // 4 Kbyte steps, DA bit kept out
wire [7:0] lo_bound = lower_reg[`CSW_BASE_HI:`CSW_BOUND_LO];
wire [9:0] mid_base = mid_reg[`CSW_BASE_HI:`CSW_BASE_LO];
wire [2:0] size_sel = aux_reg[`CSW_AUX_SIZE_HI:`CSW_AUX_SIZE_LO];
wire [9:0] mid_span = 10'h8 << size_sel;    // 8K up to 512K
wire [9:0] p_base   = pbase_reg[`CSW_BASE_HI:`CSW_BASE_LO];
wire       p_mem    = aux_reg[`CSW_AUX_MEM_BIT];
wire       mid_en   = mid_seen_reg & aux_seen_reg;
wire       per_en   = pbase_seen_reg & aux_seen_reg;
// 2 Kbyte window above base holds the seven 256-byte blocks
wire       p_space  = p_mem ? ~cycle_io : cycle_io; // [RULE21]
wire [9:0] p_off    = a_hi - p_base;
wire [2:0] p_blk    = {p_off[0], cycle_addr[9:8]};
wire       p_win    = per_en & p_space & (p_off[9:1] == 9'h000);
// Memory regions; a top boundary: region is addr >= bound
wire       up_hit   = ~cycle_io & (a_hi[9:2] >= up_bound); // [RULE3] [RULE16]
wire       lo_hit   = ~cycle_io & lower_en_reg & (a_hi[9:2] <= lo_bound);
wire [9:0] m_off    = a_hi - mid_base;
wire       mid_hit  = ~cycle_io & mid_en & (m_off < mid_span) & ~up_hit & ~lo_hit; // [RULE18]
wire       pcb_hit  = cycle_io & (a_hi == `CSW_PCB_BASE); // [RULE10]
wire       p_as_adr = aux_reg[`CSW_AUX_ADDR_BIT];

// ----------------------------------------------------------------------
// Cycle sequencer
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_RDY  = 2'h2;
localparam ST_TAIL = 2'h3;

reg  [1:0]  state_reg;
reg  [1:0]  state_next;
reg  [3:0]  wcnt_reg;                      // Waits remaining
reg  [3:0]  wcnt_next;
reg         use_rdy_reg;                   // External ready honoured
reg  [3:0]  cyc_wait;                      // Decoded waits for new cycle
reg         cyc_rdy;                       // Decoded ready use for new cycle
reg  [12:0] sel_next;                      // Decoded selects, active high
reg         da_next;                       // Decoded address disable
reg         mid_dly_reg;                   // Midrange lag stage
reg  [3:0]  mid_q_reg;                     // Lagged midrange hits

// Select and timing decode; overlapping selects are assumed
// to share settings, so the first match sets the timing.
always @* begin
   sel_next = 13'h0000;
   cyc_wait = 4'h0;
   cyc_rdy  = 1'b0;
   da_next  = 1'b0;
   if (pcb_hit) begin
      cyc_wait = 4'h0; // [RULE10] [RULE12]
      cyc_rdy  = 1'b0;
   end else if (up_hit) begin
      sel_next[0] = 1'b1;
      cyc_wait    = wait_of(upper_reg, 1'b0);
      cyc_rdy     = upper_reg[`CSW_RDY_BIT];
      da_next     = upper_reg[`CSW_DA_BIT]; // [RULE11]
   end else if (lo_hit) begin
      sel_next[1] = 1'b1;
      cyc_wait    = wait_of(lower_reg, 1'b0);
      cyc_rdy     = lower_reg[`CSW_RDY_BIT];
      da_next     = lower_reg[`CSW_DA_BIT]; // [RULE11]
   end else if (mid_hit) begin
      // Timing applies even while the pins serve as general I/O
      sel_next[2 + m_off[1:0]] = 1'b1; // [RULE13] [RULE5]
      cyc_wait = wait_of(mid_reg, 1'b0);
      cyc_rdy  = mid_reg[`CSW_RDY_BIT];
   end else if (p_win) begin
      if (p_blk < 3'h5) begin
         sel_next[6 + p_blk] = 1'b1; // [RULE4] [RULE13] [RULE14]
         cyc_wait = wait_of(pbase_reg, 1'b1); // [RULE7]
         cyc_rdy  = pbase_reg[`CSW_RDY_BIT];
      end else if (!p_as_adr && p_blk != 3'h7) begin
         sel_next[6 + p_blk] = 1'b1; // [RULE22]
         cyc_wait = wait_of(aux_reg, 1'b0);
         cyc_rdy  = aux_reg[`CSW_RDY_BIT];
      end
   end
end

// Wait sequence: ready is heard while programmed waits remain;
// a late ready then costs two more waits.
always @* begin
   state_next = state_reg;
   wcnt_next  = wcnt_reg;
   case (state_reg)
      ST_IDLE: begin
         if (cycle_start) begin
            wcnt_next  = cyc_wait;
            // Zero waits finish at once; midrange keeps one cycle for its lag
            if (cyc_wait == 4'h0 && sel_next[5:2] == 4'h0)
               state_next = ST_TAIL;
            else
               state_next = ST_WAIT;
         end
      end
      ST_WAIT: begin
         if (wcnt_reg != 4'h0)
            wcnt_next = wcnt_reg - 4'h1; // [RULE8]
         if (use_rdy_reg && !rdy_s2_reg && wcnt_reg != 4'h0)
            state_next = ST_RDY; // [RULE9]
         else if (wcnt_reg <= 4'h1)
            state_next = ST_TAIL;
      end
      ST_RDY: begin
         if (rdy_s2_reg) begin
            wcnt_next  = 4'h2; // [RULE9]
            state_next = ST_WAIT;
         end
      end
      ST_TAIL: begin
         if (cycle_done)
            state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
   endcase
end

assign cycle_ready = (state_reg == ST_TAIL);

// Sequencer state and select outputs
always @(posedge core_clk) begin
   if (!reset_n) begin
      state_reg            <= ST_IDLE;
      wcnt_reg             <= 4'h0;
      use_rdy_reg          <= 1'b0;
      upper_mem_select_n   <= 1'b1;
      lower_mem_select_n   <= 1'b1;
      mid_mem_selects_n    <= 4'hf;
      periph_selects_low_n <= 4'hf;
      periph_select_four_n <= 1'b1;
      periph_select_five_n <= 1'b1;
      periph_select_six_n  <= 1'b1;
      pcb_select           <= 1'b0;
      address_disable      <= 1'b0;
      addr_pins_mode       <= 1'b0;
      mid_dly_reg          <= 1'b0;
      mid_q_reg            <= 4'h0;
   end else begin
      state_reg      <= state_next;
      wcnt_reg       <= wcnt_next;
      addr_pins_mode <= p_as_adr; // [RULE22]
      if (state_reg == ST_IDLE && cycle_start) begin
         use_rdy_reg          <= cyc_rdy;
         upper_mem_select_n   <= ~sel_next[0]; // [RULE24] [RULE3]
         lower_mem_select_n   <= ~sel_next[1];
         mid_q_reg            <= sel_next[5:2];
         mid_dly_reg          <= 1'b1;
         periph_selects_low_n <= ~sel_next[9:6]; // [RULE24]
         periph_select_four_n <= ~sel_next[10];
         periph_select_five_n <= ~sel_next[11];
         periph_select_six_n  <= ~sel_next[12];
         pcb_select           <= pcb_hit;
         address_disable      <= da_next; // [RULE11]
      end else if (state_reg == ST_TAIL && cycle_done) begin
         upper_mem_select_n   <= 1'b1; // [RULE24]
         lower_mem_select_n   <= 1'b1;
         mid_mem_selects_n    <= 4'hf;
         periph_selects_low_n <= 4'hf;
         periph_select_four_n <= 1'b1;
         periph_select_five_n <= 1'b1;
         periph_select_six_n  <= 1'b1;
         pcb_select           <= 1'b0;
         address_disable      <= 1'b0;
         mid_dly_reg          <= 1'b0;
      end else if (mid_dly_reg) begin
         // Midrange lags one core cycle, the half bus clock
         mid_mem_selects_n <= ~mid_q_reg; // [RULE20]
         mid_dly_reg       <= 1'b0;
      end
   end
end

// ----------------------------------------------------------------------
// Register read port, data one cycle after strobe
// ----------------------------------------------------------------------
always @(posedge core_clk) begin
   if (!reset_n)
      reg_rdata <= `CSW_ZERO16;
   else if (reg_rd) begin
      case (reg_addr)
         `CSW_IDX_UPPER:  reg_rdata <= upper_reg;
         `CSW_IDX_LOWER:  reg_rdata <= lower_reg;
         `CSW_IDX_PBASE:  reg_rdata <= pbase_reg;
         `CSW_IDX_MID:    reg_rdata <= mid_reg;
         `CSW_IDX_AUX:    reg_rdata <= aux_reg;
         `CSW_IDX_RSTCFG: reg_rdata <= rstcfg_reg; // [RULE1]
         `CSW_IDX_STATUS: reg_rdata <= {10'h000, state_reg, lower_en_reg, mid_en, per_en, use_rdy_reg};
         default:         reg_rdata <= `CSW_ZERO16;
      endcase
   end
end

endmodule // csw_unit

// file: verif/csw_unit_checker.sv
/*
 Checker for the chip-select unit: select timing, ready and register port.
 Assumes it is bound to csw_unit and sees only that module's ports.
*/
`timescale 1ns/10ps

module csw_unit_checker #(
   parameter DW = 16
)(
   input wire          core_clk,
   input wire          reset_n,
   input wire          cycle_start,
   input wire          cycle_done,
   input wire [2:0]    reg_addr,
   input wire          reg_rd,
   input wire [DW-1:0] reg_rdata,
   input wire          upper_mem_select_n,
   input wire          lower_mem_select_n,
   input wire [3:0]    mid_mem_selects_n,
   input wire [3:0]    periph_selects_low_n,
   input wire          periph_select_five_n,
   input wire          periph_select_six_n,
   input wire          pcb_select,
   input wire          address_disable,
   input wire          cycle_ready,
   input wire          addr_pins_mode
);
   // -------------------------------------------------------------
   // Properties, one clock domain
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // Select falls as a cycle opens
   sequence upper_open;
      $fell(upper_mem_select_n);
   endsequence
   sequence mid_open;
      $fell(&mid_mem_selects_n);
   endsequence
   // Two config reads two cycles apart
   sequence cfg_reads;
      reg_rd && reg_addr == 3'h5 ##2 reg_rd && reg_addr == 3'h5;
   endsequence

   upper_start_a: assert property (upper_open |-> $past(cycle_start))
      else $error("upper select fell without a cycle start");
   lower_start_a: assert property ($fell(lower_mem_select_n) |-> $past(cycle_start))
      else $error("lower select fell without a cycle start");
   mid_lag_a: assert property (mid_open |-> $past(cycle_start, 2))
      else $error("midrange select not one cycle later");
   pcb_nowait_a: assert property ($rose(pcb_select) |-> cycle_ready)
      else $error("control block access waited");
   done_release_a: assert property (cycle_ready && cycle_done |=>
      upper_mem_select_n && lower_mem_select_n && &mid_mem_selects_n && !cycle_ready)
      else $error("selects held after cycle end");
   addr_mode_a: assert property (addr_pins_mode |-> periph_select_five_n && periph_select_six_n)
      else $error("upper peripheral select in address mode");
   da_scope_a: assert property (address_disable |-> !upper_mem_select_n || !lower_mem_select_n)
      else $error("address disable outside upper or lower");
   cfg_hold_a: assert property (cfg_reads |=> reg_rdata == $past(reg_rdata, 2))
      else $error("reset config value changed");
   plow_start_a: assert property ($fell(&periph_selects_low_n) |-> $past(cycle_start))
      else $error("peripheral select fell without a cycle start");
endmodule // csw_unit_checker

bind csw_unit csw_unit_checker #(.DW(DW)) i_chk (
   .core_clk(core_clk), .reset_n(reset_n), .cycle_start(cycle_start), .cycle_done(cycle_done),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
   .mid_mem_selects_n(mid_mem_selects_n), .periph_selects_low_n(periph_selects_low_n),
   .periph_select_five_n(periph_select_five_n), .periph_select_six_n(periph_select_six_n),
   .pcb_select(pcb_select), .address_disable(address_disable), .cycle_ready(cycle_ready),
   .addr_pins_mode(addr_pins_mode));

// file: verif/csw_mem_model.sv
/*
 Far-side model: board pattern on the bus during reset, and memory ready.
 Assumes any_select is high while some select output is low.
*/
`timescale 1ns/10ps

module csw_mem_model (
   input  wire        core_clk,
   input  wire        reset_n,
   input  wire [15:0] cfg_pattern,
   input  wire [7:0]  slow_cycles,
   input  wire        any_select,
   output wire [15:0] muxed_addr_data_bus,
   output wire        ext_ready
);
   // -------------------------------------------------------------
   // Bus pattern and ready stall
   // -------------------------------------------------------------
   reg [2:0]  hold_reg  = 3'h4;     // Cycles the pattern outlives reset
   reg [15:0] float_reg = 16'h0000; // Undriven bus, changes every cycle
   reg [7:0]  stall_reg = 8'h00;    // Ready delay left in this access

   // Pattern held through reset, then the bus floats
   assign muxed_addr_data_bus = (hold_reg != 3'h0) ? cfg_pattern : float_reg;
   // Prompt memory ties ready high; slow one holds it low until stall ends
   assign ext_ready = (slow_cycles == 8'h00) || (any_select && stall_reg == 8'h00);

   // Pattern hold and floating bus
   always @(posedge core_clk) begin
      if (!reset_n) begin
         hold_reg <= 3'h4;
      end else if (hold_reg != 3'h0) begin
         hold_reg <= hold_reg - 3'h1;
      end
      float_reg <= ~muxed_addr_data_bus;
   end

   // Stall reloads while idle, counts down while selected
   always @(posedge core_clk) begin
      if (!any_select) begin
         stall_reg <= slow_cycles;
      end else if (stall_reg != 8'h00) begin
         stall_reg <= stall_reg - 8'h01;
      end
   end
endmodule // csw_mem_model

// file: verif/chip_select_wait_state_unit_test.sv
/*
 Testbench for the chip-select unit: register port tasks and bus cycles.
 Assumes the far-side model supplies ready and the reset pattern.
*/
`timescale 1ns/10ps
`include "csw_map.vh"

module chip_select_wait_state_unit_test;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   reg         core_clk = 1'b0;
   reg         reset_n = 1'b0;
   reg         cycle_start = 1'b0, cycle_io = 1'b0, cycle_done = 1'b0;
   reg  [19:0] cycle_addr = 20'h00000;
   reg  [2:0]  reg_addr = 3'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [7:0]  slow = 8'h00;         // Memory ready delay
   wire [15:0] bus, reg_rdata;
   wire        ext_ready, cycle_ready, periph_control_block, da, apm, u_n, l_n, p4_n, p5_n, p6_n;
   wire [3:0]  m_n, p_n;
   wire [14:0] sel = {da, u_n, l_n, m_n, p_n, p4_n, p5_n, p6_n, periph_control_block}; // Idle 15'h3ffe
   integer     err_count = 0, total_checks = 0, cyc = 0, n, c;
   reg  [14:0] v1, v2;
   reg  [15:0] d;
   integer     wt [0:7] = '{0, 1, 2, 3, 5, 7, 9, 15}; // Extended wait table

   always #2 core_clk = ~core_clk;

   csw_unit i_dut (.core_clk(core_clk), .reset_n(reset_n), .muxed_addr_data_bus(bus),
      .cycle_start(cycle_start), .cycle_addr(cycle_addr), .cycle_io(cycle_io), .cycle_done(cycle_done),
      .ext_ready(ext_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .upper_mem_select_n(u_n), .lower_mem_select_n(l_n), .mid_mem_selects_n(m_n),
      .periph_selects_low_n(p_n), .periph_select_four_n(p4_n), .periph_select_five_n(p5_n),
      .periph_select_six_n(p6_n), .pcb_select(periph_control_block), .address_disable(da), .cycle_ready(cycle_ready),
      .addr_pins_mode(apm));
   csw_mem_model i_mem (.core_clk(core_clk), .reset_n(reset_n), .cfg_pattern(16'ha5c3),
      .slow_cycles(slow), .any_select(sel[13:1] != 13'h1fff), .muxed_addr_data_bus(bus),
      .ext_ready(ext_ready));

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task chk(input [15:0] exp, input [15:0] got, input [8*8-1:0] what);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
   endtask
   task reg_write(input [2:0] a, input [15:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task reg_read(input [2:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata; // Data holds until the next read
   endtask
   // One bus cycle; v1 and v2 are the selects one and two cycles in
   task run_cycle(input [19:0] a, input io);
      @(posedge core_clk);
      cycle_start <= 1'b1; cycle_addr <= a; cycle_io <= io;
      @(posedge core_clk);
      cycle_start <= 1'b0; cycle_done <= 1'b1;
      #1 v1 = sel; v2 = sel; n = 1;
      while (cycle_ready !== 1'b1 && n < 60) begin
         @(posedge core_clk);
         #1 n = n + 1;
         if (n == 2) v2 = sel;
      end
      @(posedge core_clk);
      cycle_done <= 1'b0;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard, far above the run length
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         complete_run;
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      reg_read(3'h5); chk(16'ha5c3, d, "rstcfg");
      reg_read(3'h5); chk(16'ha5c3, d, "rstcfg");
      reg_read(3'h0); chk(`CSW_UPPER_RST, d, "upper");
      reg_read(3'h7); chk(16'h0000, d, "unmapped");
      $display("reset test done");
      run_cycle(20'hffff0, 1'b0); chk(15'h1ffe, v1, "usel"); chk(4, n, "uwait");
      slow <= 8'd10;
      run_cycle(20'hffff0, 1'b0); chk(1, n >= 13 && n <= 18, "late");
      run_cycle(20'hffc00, 1'b1); chk(15'h3fff, v1, "pcb"); chk(1, n, "pcbwait");
      slow <= 8'd0;
      reg_write(3'h0, 16'h8082);
      run_cycle(20'h80000, 1'b0); chk(15'h5ffe, v1, "uda"); chk(3, n, "uwait");
      run_cycle(20'h7fc00, 1'b0); chk(15'h3ffe, v1, "ubelow");
      $display("upper test done");
      run_cycle(20'h00000, 1'b0); chk(15'h3ffe, v1, "loff");
      reg_read(3'h1);
      run_cycle(20'h00000, 1'b0); chk(15'h2ffe, v1, "lon"); chk(1, n, "lwait");
      reg_write(3'h3, 16'h4003);
      run_cycle(20'h40000, 1'b0); chk(15'h3ffe, v1, "moff");
      reg_write(3'h2, 16'h0080);
      run_cycle(20'h00800, 1'b1); chk(15'h3ffe, v1, "poff");
      reg_write(3'h4, 16'h0000);
      run_cycle(20'h40000, 1'b0); chk(15'h3ffe, v1, "mlag"); chk(15'h3efe, v2, "mon");
      chk(4, n, "mwait");
      $display("lower and mid test done");
      for (c = 0; c < 8; c = c + 1) begin
         reg_write(3'h2, 16'h0080 | {c[2], 1'b0, c[1:0]});
         run_cycle(20'h00800 + (c % 4) * 256, 1'b1);
         chk(15'h3ffe & ~(15'h1 << (4 + c % 4)), v1, "plow");
         chk(wt[c] + 1, n, "pwait");
      end
      for (c = 4; c < 7; c = c + 1) begin
         run_cycle(20'h00800 + c * 256, 1'b1); chk(15'h3ffe & ~(15'h1 << (7 - c)), v1, "phigh");
      end
      reg_write(3'h4, 16'h0080);
      run_cycle(20'h00d00, 1'b1); chk(15'h3ffe, v1, "paddr"); chk(1, apm, "apm");
      $display("peripheral test done");
      complete_run;
   end
endmodule // chip_select_wait_state_unit_test
